//--- rtl/canmb_top.sv
`timescale 1ns/100ps
module canmb_top (
  input logic mclk, // 20 MHz module clock
  input logic resetn, // synchronous reset
  input logic [canmb_pkg::ADDR_W-1:0] avs_address, // byte address
  input logic avs_read, // read request
  input logic avs_write, // write request
  input logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // low marks the answer
  input logic rxByteWe, // engine stores a received byte
  input logic [3:0] rxByteIdx, // byte index in frame
  input logic [7:0] rxByteData, // received byte
  input logic rxFrameOk, // pulse: frame received correctly
  input logic rxFrameOwn, // frame was sent by this node
  input logic txArbReq, // pulse: engine arbitrates
  input logic txStart, // pulse: selected frame goes on bus
  input logic txDone, // pulse: frame sent successfully
  input logic txErr, // pulse: send failed or arbitration lost
  input logic [3:0] txRdIdx, // tx byte the engine wants
  output logic [7:0] txRdData, // byte of selected buffer
  output logic txSelValid, // pulse: selection ready
  output logic [1:0] txSelIdx, // selected buffer
  output logic txPending, // some buffer scheduled
  output logic ackSuppress, // do not acknowledge own frame
  output logic loopBack, // loop-back mode
  output logic intRx, // receive interrupt
  output logic intTx, // transmit interrupt
  output logic intOvr // overrun interrupt
);
  import canmb_pkg::*;

  typedef struct packed {
    canmb_frame_t rx_background_buffer;
    canmb_frame_t rx_foreground_buffer;
    logic [31:0] idShadow;
    logic bgFull;
    logic [2:0] bgHit;
    logic rxFull;
    logic ovr;
    logic rxIe;
    logic ovrIe;
    logic [2:0] hit;
    logic [1:0] mode;
    logic loopBack;
    logic [63:0] acc;
    logic [63:0] msk;
    canmb_frame_t [TX_BUFS-1:0] txBuf;
    logic [TX_BUFS-1:0][7:0] local_priority_field;
    logic [TX_BUFS-1:0] txEmpty;
    logic [TX_BUFS-1:0] txIe;
    logic [TX_BUFS-1:0] abtReq;
    logic [TX_BUFS-1:0] abtAck;
    logic actValid;
    logic [1:0] actIdx;
    logic selValid;
    logic [1:0] selIdx;
    logic [7:0] txRdData;
    logic ack;
    logic waitReq;
    logic [31:0] readData;
    logic intRx;
    logic intTx;
    logic intOvr;
    logic ackSup;
    logic txPend;
  } canmb_state_t;

  canmb_state_t st_q;
  canmb_state_t st_d;
  canmb_flt_if fltIf ();

  // one 32-bit word of a 13-byte frame, bytes past the end read zero
  function automatic logic [31:0] frameWord(input canmb_frame_t f, input logic [1:0] w);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < 4; k++) begin
      if (4 * int'(w) + k < FRAME_BYTES) begin
        r[8*k +: 8] = f[4 * int'(w) + k];
      end
    end
    return r;
  endfunction : frameWord

  function automatic canmb_frame_t frameWr(input canmb_frame_t f, input logic [1:0] w,
                                           input logic [31:0] d);
    canmb_frame_t r;
    r = f;
    for (int k = 0; k < 4; k++) begin
      if (4 * int'(w) + k < FRAME_BYTES) begin
        r[4 * int'(w) + k] = d[8*k +: 8];
      end
    end
    return r;
  endfunction : frameWr

  // strict compare keeps the lower index on a tie; result is {found, index}
  function automatic logic [2:0] pickBuf(input logic [TX_BUFS-1:0] sched,
                                         input logic [TX_BUFS-1:0][7:0] pr);
    logic found;
    logic [1:0] idx;
    found = 1'b0;
    idx = 2'h0;
    for (int i = 0; i < TX_BUFS; i++) begin
      if (sched[i] && (!found || pr[i] < pr[idx])) begin
        found = 1'b1;
        idx = 2'(i);
      end
    end
    return {found, idx};
  endfunction : pickBuf

  // filter looks at the identifier of the frame now arriving
  assign fltIf.id = st_q.idShadow;
  assign fltIf.acc = st_q.acc;
  assign fltIf.msk = st_q.msk;
  assign fltIf.mode = st_q.mode;

  canmb_filter uFilter (
    .fi(fltIf.flt)
  );

  always_comb begin : nextState
    logic req;
    logic wrEn;
    logic own;
    logic [2:0] pick;
    logic [31:0] rd;
    logic [31:0] wd;
    req = avs_read | avs_write;
    wrEn = avs_write & st_q.ack;
    own = rxFrameOwn & ~st_q.loopBack;
    pick = pickBuf(~st_q.txEmpty, st_q.local_priority_field);
    rd = 32'h0;
    wd = avs_writedata;
    st_d = st_q;

    // register read mux
    case (avs_address)
      OFS_RX_FLAG: begin
        rd[RXF_BIT] = st_q.rxFull;
        rd[OVR_BIT] = st_q.ovr;
        rd[RXIE_BIT] = st_q.rxIe;
        rd[OVRIE_BIT] = st_q.ovrIe;
      end
      OFS_TX_FLAG: begin
        rd[TXE_LSB +: TX_BUFS] = st_q.txEmpty;
        rd[TXIE_LSB +: TX_BUFS] = st_q.txIe;
      end
      OFS_TX_CTRL: begin
        rd[ABORT_REQUEST_LSB +: TX_BUFS] = st_q.abtReq;
        rd[ABORT_ACKNOWLEDGE_LSB +: TX_BUFS] = st_q.abtAck;
      end
      OFS_ACC_CTRL: begin
        rd[HIT_LSB +: 3] = st_q.hit;
        rd[MODE_LSB +: 2] = st_q.mode;
        rd[LOOP_BIT] = st_q.loopBack;
      end
      OFS_ACC0: rd = st_q.acc[31:0];
      OFS_ACC1: rd = st_q.acc[63:32];
      OFS_MSK0: rd = st_q.msk[31:0];
      OFS_MSK1: rd = st_q.msk[63:32];
      OFS_LOCAL_PRIORITY_FIELD: rd[8*TX_BUFS-1:0] = st_q.local_priority_field;
      default: begin
        if (avs_address[7:6] == RGN_RX && avs_address[5:4] == 2'h0) begin
          rd = frameWord(st_q.rx_foreground_buffer, avs_address[3:2]);
        end else if (avs_address[7:6] == RGN_TX && int'(avs_address[5:4]) < TX_BUFS) begin
          rd = frameWord(st_q.txBuf[avs_address[5:4]], avs_address[3:2]);
        end
      end
    endcase

    // bus slave: answer one cycle after the request, data valid with it
    st_d.ack = req & ~st_q.ack;
    st_d.waitReq = ~st_d.ack;
    if (req && !st_q.ack) begin
      st_d.readData = rd;
    end

    // software writes land at the edge where waitrequest is seen low
    if (wrEn) begin
      case (avs_address)
        OFS_RX_FLAG: begin
          if (wd[RXF_BIT]) begin
            st_d.rxFull = 1'b0;
          end
          if (wd[OVR_BIT] && !(st_q.bgFull && st_q.rxFull)) begin
            st_d.ovr = 1'b0;
          end
          st_d.rxIe = wd[RXIE_BIT];
          st_d.ovrIe = wd[OVRIE_BIT];
        end
        OFS_TX_FLAG: begin
          // clearing an empty flag schedules the buffer
          st_d.txEmpty = st_q.txEmpty & ~wd[TXE_LSB +: TX_BUFS];
          st_d.abtAck = st_q.abtAck & ~wd[TXE_LSB +: TX_BUFS];
          st_d.txIe = wd[TXIE_LSB +: TX_BUFS];
        end
        OFS_TX_CTRL: begin
          // abort only makes sense on a scheduled buffer
          st_d.abtReq = st_q.abtReq | (wd[ABORT_REQUEST_LSB +: TX_BUFS] & ~st_q.txEmpty);
        end
        OFS_ACC_CTRL: begin
          st_d.mode = wd[MODE_LSB +: 2];
          st_d.loopBack = wd[LOOP_BIT];
        end
        OFS_ACC0: st_d.acc[31:0] = wd;
        OFS_ACC1: st_d.acc[63:32] = wd;
        OFS_MSK0: st_d.msk[31:0] = wd;
        OFS_MSK1: st_d.msk[63:32] = wd;
        OFS_LOCAL_PRIORITY_FIELD: st_d.local_priority_field = wd[8*TX_BUFS-1:0];
        default: begin
          if (avs_address[7:6] == RGN_TX && int'(avs_address[5:4]) < TX_BUFS) begin
            st_d.txBuf[avs_address[5:4]] =
              frameWr(st_q.txBuf[avs_address[5:4]], avs_address[3:2], wd);
          end
        end
      endcase
    end

    // the identifier shadow follows every frame so overrun can still be judged
    if (rxByteWe && int'(rxByteIdx) < 4) begin
      st_d.idShadow[8*int'(rxByteIdx) +: 8] = rxByteData;
    end
    // background is overwritten whatever the filter says, unless it is holding
    if (rxByteWe && !st_q.bgFull && int'(rxByteIdx) < FRAME_BYTES) begin
      st_d.rx_background_buffer[rxByteIdx] = rxByteData;
    end

    // end of a good frame; own frames stop here unless in loop-back
    if (rxFrameOk && !own && fltIf.accept) begin
      if (st_q.bgFull) begin
        st_d.ovr = 1'b1;
      end else if (!st_q.rxFull) begin
        st_d.rx_foreground_buffer = st_q.rx_background_buffer;
        st_d.rxFull = 1'b1;
        st_d.hit = fltIf.hit;
      end else begin
        st_d.bgFull = 1'b1;
        st_d.bgHit = fltIf.hit;
      end
    end
    // a held frame moves forward once the foreground is freed
    if (st_q.bgFull && !st_q.rxFull) begin
      st_d.rx_foreground_buffer = st_q.rx_background_buffer;
      st_d.rxFull = 1'b1;
      st_d.hit = st_q.bgHit;
      st_d.bgFull = 1'b0;
    end

    // selection runs afresh on each arbitration, retries included
    st_d.selValid = txArbReq & pick[2];
    if (txArbReq && pick[2]) begin
      st_d.selIdx = pick[1:0];
    end
    // lock the buffer only if it was not aborted meanwhile
    if (txStart && st_q.selValid == 1'b0 && !st_q.txEmpty[st_q.selIdx]) begin
      st_d.actValid = 1'b1;
      st_d.actIdx = st_q.selIdx;
    end else if (txStart && !st_q.txEmpty[st_q.selIdx]) begin
      st_d.actValid = 1'b1;
      st_d.actIdx = st_q.selIdx;
    end
    if (txErr) begin
      st_d.actValid = 1'b0;
    end
    if (txDone && st_q.actValid) begin
      st_d.txEmpty[st_q.actIdx] = 1'b1;
      st_d.abtAck[st_q.actIdx] = 1'b0;
      st_d.abtReq[st_q.actIdx] = 1'b0;
      st_d.actValid = 1'b0;
    end
    // a frame on the bus cannot be aborted
    for (int i = 0; i < TX_BUFS; i++) begin
      if (st_q.abtReq[i] && !st_q.txEmpty[i] &&
          !(st_q.actValid && int'(st_q.actIdx) == i)) begin
        st_d.txEmpty[i] = 1'b1;
        st_d.abtAck[i] = 1'b1;
        st_d.abtReq[i] = 1'b0;
      end
    end

    st_d.txRdData = (int'(txRdIdx) < FRAME_BYTES) ? st_q.txBuf[st_q.selIdx][txRdIdx] : 8'h00;

    // registered outputs; masking kept local, vectoring lives elsewhere
    st_d.intRx = st_d.rxFull & st_d.rxIe;
    st_d.intTx = |(st_d.txEmpty & st_d.txIe);
    st_d.intOvr = st_d.ovr & st_d.ovrIe;
    st_d.ackSup = st_d.actValid & ~st_d.loopBack;
    st_d.txPend = |(~st_d.txEmpty);
  end

  // state register; reset leaves all buffers empty and the filter open
  always_ff @(posedge mclk) begin : stateReg
    if (!resetn) begin
      st_q <= '0;
      st_q.waitReq <= 1'b1;
      st_q.txEmpty <= '1;
      st_q.msk <= MSK_RST;
      st_q.mode <= MODE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.readData;
  assign avs_waitrequest = st_q.waitReq;
  assign txRdData = st_q.txRdData;
  assign txSelValid = st_q.selValid;
  assign txSelIdx = st_q.selIdx;
  assign txPending = st_q.txPend;
  assign ackSuppress = st_q.ackSup;
  assign loopBack = st_q.loopBack;
  assign intRx = st_q.intRx;
  assign intTx = st_q.intTx;
  assign intOvr = st_q.intOvr;

  // helper: lowest priority value among scheduled buffers
  logic [7:0] lowPrio;
  always_comb begin : lowPrioCalc
    lowPrio = 8'hff;
    for (int i = 0; i < TX_BUFS; i++) begin
      if (!st_q.txEmpty[i] && st_q.local_priority_field[i] < lowPrio) begin
        lowPrio = st_q.local_priority_field[i];
      end
    end
  end

  AST_RXF_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
    st_q.rxFull && !(avs_write && st_q.ack && avs_address == OFS_RX_FLAG)
    |=> st_q.rxFull)
    else $error("receive-full dropped without a clear");
  AST_CLOSED: assert property (@(posedge mclk) disable iff (!resetn)
    st_q.mode == MODE_CLOSED && !st_q.rxFull && !st_q.bgFull |-> !fltIf.accept ##1 !st_q.rxFull)
    else $error("closed filter let a frame into the foreground");
  AST_OWN_NO_COPY: assert property (@(posedge mclk) disable iff (!resetn)
    rxFrameOk && rxFrameOwn && !st_q.loopBack && !st_q.rxFull && !st_q.bgFull
    |=> !st_q.rxFull ##1 !st_q.rxFull)
    else $error("own frame reached the foreground");
  AST_OVERRUN: assert property (@(posedge mclk) disable iff (!resetn)
    rxFrameOk && fltIf.accept && st_q.bgFull && (!rxFrameOwn || st_q.loopBack)
    |=> st_q.ovr && $stable(st_q.rx_foreground_buffer))
    else $error("overrun not flagged");
  AST_BG_FORWARD: assert property (@(posedge mclk) disable iff (!resetn)
    st_q.bgFull && !st_q.rxFull |=> st_q.rxFull && !st_q.bgFull && st_q.rx_foreground_buffer == $past(st_q.rx_background_buffer))
    else $error("held frame not moved forward");
  AST_TX_DONE: assert property (@(posedge mclk) disable iff (!resetn)
    txDone && st_q.actValid |=> st_q.txEmpty[$past(st_q.actIdx)] && !st_q.actValid)
    else $error("sent buffer not released");
  AST_SELECT: assert property (@(posedge mclk) disable iff (!resetn)
    txArbReq && !(&st_q.txEmpty) && !(avs_write && st_q.ack)
    |=> st_q.selValid && st_q.local_priority_field[st_q.selIdx] == $past(lowPrio))
    else $error("selected buffer is not the most urgent");
  AST_NO_ABORT_ON_BUS: assert property (@(posedge mclk) disable iff (!resetn)
    st_q.actValid && !st_q.txEmpty[st_q.actIdx] && !txDone
    |=> !st_q.txEmpty[$past(st_q.actIdx)])
    else $error("frame on the bus was aborted");
  AST_ABORT_ACKNOWLEDGE_SENT: assert property (@(posedge mclk) disable iff (!resetn)
    txDone && st_q.actValid |=> !st_q.abtAck[$past(st_q.actIdx)])
    else $error("abort-acknowledge set for a sent frame");
endmodule : canmb_top

//--- inc/canmb_pkg.sv
package canmb_pkg;
  // frame geometry
  localparam int FRAME_BYTES = 13;
  localparam int TX_BUFS = 3;
  localparam int ADDR_W = 8;
  typedef logic [FRAME_BYTES-1:0][7:0] canmb_frame_t;
  // filter modes
  localparam logic [1:0] MODE_32 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_8 = 2'h2;
  localparam logic [1:0] MODE_CLOSED = 2'h3;
  // byte offsets of control words
  localparam logic [7:0] OFS_RX_FLAG = 8'h00;
  localparam logic [7:0] OFS_TX_FLAG = 8'h04;
  localparam logic [7:0] OFS_TX_CTRL = 8'h08;
  localparam logic [7:0] OFS_ACC_CTRL = 8'h0c;
  localparam logic [7:0] OFS_ACC0 = 8'h10;
  localparam logic [7:0] OFS_ACC1 = 8'h14;
  localparam logic [7:0] OFS_MSK0 = 8'h18;
  localparam logic [7:0] OFS_MSK1 = 8'h1c;
  localparam logic [7:0] OFS_LOCAL_PRIORITY_FIELD = 8'h20;
  // buffer windows: addr[7:6]; rx at 0x40, tx n at 0x80 + 0x10*n
  localparam logic [1:0] RGN_RX = 2'h1;
  localparam logic [1:0] RGN_TX = 2'h2;
  // field positions
  localparam int RXF_BIT = 0;
  localparam int OVR_BIT = 1;
  localparam int RXIE_BIT = 4;
  localparam int OVRIE_BIT = 5;
  localparam int TXE_LSB = 0;
  localparam int TXIE_LSB = 4;
  localparam int ABORT_REQUEST_LSB = 0;
  localparam int ABORT_ACKNOWLEDGE_LSB = 4;
  localparam int HIT_LSB = 0;
  localparam int MODE_LSB = 4;
  localparam int LOOP_BIT = 8;
  // reset values
  localparam logic [1:0] MODE_RST = MODE_32;
  localparam logic [63:0] MSK_RST = 64'hffffffffffffffff;
endpackage : canmb_pkg

//--- inc/canmb_flt_if.sv
`timescale 1ns/100ps
interface canmb_flt_if;
  logic [31:0] id;
  logic [63:0] acc;
  logic [63:0] msk;
  logic [1:0] mode;
  logic accept;
  logic [2:0] hit;
  modport ctl (output id, acc, msk, mode, input accept, hit);
  modport flt (input id, acc, msk, mode, output accept, hit);
endinterface : canmb_flt_if

//--- rtl/canmb_filter.sv
`timescale 1ns/100ps
module canmb_filter (
  canmb_flt_if.flt fi // identifier in, verdict out
);
  import canmb_pkg::*;

  typedef struct packed {
    logic accept;
    logic [2:0] hit;
  } canmb_fres_t;

  canmb_fres_t res;

  // a set mask bit makes the identifier bit don't care
  function automatic logic byteHit(input logic [7:0] idb, input logic [7:0] accb,
                                   input logic [7:0] mskb);
    return ((idb ^ accb) & ~mskb) == 8'h00;
  endfunction : byteHit

  // filter f compares the first per id bytes with acceptance bytes f*per..
  always_comb begin : match
    int per;
    int nFlt;
    logic m;
    per = 4;
    nFlt = 2;
    m = 1'b0;
    res = '0;
    unique case (fi.mode)
      MODE_32: begin
        per = 4;
        nFlt = 2;
      end
      MODE_16: begin
        per = 2;
        nFlt = 4;
      end
      MODE_8: begin
        per = 1;
        nFlt = 8;
      end
      MODE_CLOSED: begin
        per = 1;
        nFlt = 0;
      end
    endcase
    // walk downward so the lowest matching filter is the one kept
    for (int f = 7; f >= 0; f--) begin
      m = (f < nFlt);
      for (int k = 0; k < 4; k++) begin
        if (k < per && !byteHit(fi.id[8*k +: 8], fi.acc[8*((f*per+k)%8) +: 8],
                                fi.msk[8*((f*per+k)%8) +: 8])) begin
          m = 1'b0;
        end
      end
      if (m) begin
        res.accept = 1'b1;
        res.hit = 3'(f);
      end
    end
  end

  assign fi.accept = res.accept;
  assign fi.hit = res.hit;
endmodule : canmb_filter

//--- test/canmb_engine_model.sv
`timescale 1ns/100ps
// stand-in for the bit-stream engine on the far side of the buffers
module canmb_engine_model (
  input logic mclk, // module clock
  output logic rxByteWe, // byte strobe
  output logic [3:0] rxByteIdx, // byte index
  output logic [7:0] rxByteData, // byte value
  output logic rxFrameOk, // frame good pulse
  output logic rxFrameOwn, // frame was our own
  output logic txArbReq, // arbitration pulse
  output logic txStart, // frame goes on bus
  output logic txDone, // frame sent
  output logic txErr, // frame failed
  output logic [3:0] txRdIdx, // byte wanted
  input logic [7:0] txRdData, // byte of selected buffer
  input logic txSelValid, // selection ready
  input logic [1:0] txSelIdx // selected buffer
);
  initial begin
    {rxByteWe, rxByteIdx, rxByteData, rxFrameOk, rxFrameOwn} = '0;
    {txArbReq, txStart, txDone, txErr, txRdIdx} = '0;
  end

  // bytes first, then the good-frame pulse; data line toggles once released
  task automatic send_frame(input logic [31:0] id, input logic own);
    logic [7:0] b;
    for (int i = 0; i < 13; i++) begin
      b = (i < 4) ? id[8*i+:8] : 8'h40 + 8'(i);
      rxByteWe <= 1'b1;
      rxByteIdx <= 4'(i);
      rxByteData <= b;
      @(posedge mclk);
    end
    rxByteWe <= 1'b0;
    rxByteData <= ~b;
    @(posedge mclk);
    rxFrameOk <= 1'b1;
    rxFrameOwn <= own;
    @(posedge mclk);
    rxFrameOk <= 1'b0;
    rxFrameOwn <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : send_frame

  // one arbitration round; selection is looked at in its single cycle
  task automatic arbitrate(output logic v, output logic [1:0] s);
    txArbReq <= 1'b1;
    @(posedge mclk);
    txArbReq <= 1'b0;
    @(posedge mclk);
    v = txSelValid;
    s = txSelIdx;
  endtask : arbitrate

  // k: 0 start, 1 done, 2 error
  task automatic pulse(input int k);
    if (k == 0) txStart <= 1'b1;
    else if (k == 1) txDone <= 1'b1;
    else txErr <= 1'b1;
    @(posedge mclk);
    {txStart, txDone, txErr} <= 3'h0;
    @(posedge mclk);
  endtask : pulse

  // fetch one byte of the selected buffer
  task automatic rd_byte(input logic [3:0] i, output logic [7:0] d);
    txRdIdx <= i;
    repeat (2) @(posedge mclk);
    d = txRdData;
  endtask : rd_byte
endmodule : canmb_engine_model

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
  import canmb_pkg::*;
  logic mclk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic rxByteWe, rxFrameOk, rxFrameOwn, txArbReq, txStart, txDone, txErr;
  logic [3:0] rxByteIdx, txRdIdx;
  logic [7:0] rxByteData, txRdData;
  logic txSelValid, txPending, ackSuppress, loopBack, intRx, intTx, intOvr;
  logic [1:0] txSelIdx;
  int n_mismatch = 0;
  int n_checks = 0;

  canmb_top u_dut (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rxByteWe(rxByteWe), .rxByteIdx(rxByteIdx), .rxByteData(rxByteData),
    .rxFrameOk(rxFrameOk), .rxFrameOwn(rxFrameOwn), .txArbReq(txArbReq),
    .txStart(txStart), .txDone(txDone), .txErr(txErr), .txRdIdx(txRdIdx),
    .txRdData(txRdData), .txSelValid(txSelValid), .txSelIdx(txSelIdx),
    .txPending(txPending), .ackSuppress(ackSuppress), .loopBack(loopBack),
    .intRx(intRx), .intTx(intTx), .intOvr(intOvr));

  canmb_engine_model u_eng (.mclk(mclk), .rxByteWe(rxByteWe), .rxByteIdx(rxByteIdx),
    .rxByteData(rxByteData), .rxFrameOk(rxFrameOk), .rxFrameOwn(rxFrameOwn),
    .txArbReq(txArbReq), .txStart(txStart), .txDone(txDone), .txErr(txErr),
    .txRdIdx(txRdIdx), .txRdData(txRdData), .txSelValid(txSelValid),
    .txSelIdx(txSelIdx));

  // 20 MHz clock
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one bus cycle held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    q = avs_readdata;
    if (n == 50) chk(32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  // reset state of outputs and control words, plus an unmapped read
  task automatic t_reset;
    chk(avs_waitrequest, 32'h1);
    chk({intRx, intTx, intOvr, txPending}, 32'h0);
    rd(OFS_RX_FLAG, 32'h0);
    rd(OFS_TX_FLAG, 32'h7);
    rd(OFS_ACC_CTRL, 32'h0);
    rd(OFS_MSK1, 32'hffffffff);
    rd(8'h30, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // copy, hold while full, overrun, then forwarding of the held frame
  task automatic t_rx;
    wr(OFS_RX_FLAG, 32'h30);
    u_eng.send_frame(32'h11223344, 1'b0);
    rd(OFS_RX_FLAG, 32'h31);
    chk(intRx, 32'h1);
    rd(8'h40, 32'h11223344);
    rd(8'h44, 32'h47464544);
    rd(8'h4c, 32'h4c);
    u_eng.send_frame(32'h55667788, 1'b0);
    rd(OFS_RX_FLAG, 32'h31);
    rd(8'h40, 32'h11223344);
    u_eng.send_frame(32'h99aabbcc, 1'b0);
    rd(OFS_RX_FLAG, 32'h33);
    chk(intOvr, 32'h1);
    wr(OFS_RX_FLAG, 32'h32);
    rd(OFS_RX_FLAG, 32'h33);
    wr(OFS_RX_FLAG, 32'h31);
    rd(OFS_RX_FLAG, 32'h33);
    rd(8'h40, 32'h55667788);
    wr(OFS_RX_FLAG, 32'h33);
    rd(OFS_RX_FLAG, 32'h30);
    chk({intRx, intOvr}, 32'h0);
    $display("test rx done");
  endtask : t_rx

  // own frames are kept out of the foreground unless looped back
  task automatic t_own;
    u_eng.send_frame(32'h01020304, 1'b1);
    rd(OFS_RX_FLAG, 32'h30);
    wr(OFS_ACC_CTRL, 32'h100);
    u_eng.send_frame(32'h01020304, 1'b1);
    chk(loopBack, 32'h1);
    rd(OFS_RX_FLAG, 32'h31);
    wr(OFS_RX_FLAG, 32'h31);
    wr(OFS_ACC_CTRL, 32'h0);
    $display("test own done");
  endtask : t_own

  // one filter setup, one frame, verdict and hit number
  task automatic flt(input logic [1:0] m, input logic [31:0] a0, input logic [31:0] a1,
                     input logic [31:0] m0, input logic [31:0] m1, input logic ok,
                     input logic [2:0] hit);
    wr(OFS_ACC_CTRL, {26'h0, m, 4'h0});
    wr(OFS_ACC0, a0);
    wr(OFS_ACC1, a1);
    wr(OFS_MSK0, m0);
    wr(OFS_MSK1, m1);
    u_eng.send_frame(32'h123456aa, 1'b0);
    rd(OFS_RX_FLAG, {31'h18, ok});
    if (ok) rd(OFS_ACC_CTRL, {26'h0, m, 1'b0, hit});
    wr(OFS_RX_FLAG, 32'h31);
  endtask : flt

  // every filter mode, masking and lowest-hit choice
  task automatic t_flt;
    flt(MODE_32, 32'h0, 32'h123456aa, 32'h0, 32'h0, 1'b1, 3'h1);
    flt(MODE_32, 32'h123456ab, 32'h0, 32'h1, 32'hffffffff, 1'b1, 3'h0);
    flt(MODE_16, 32'h56aa0000, 32'h56aa0000, 32'h0, 32'h0, 1'b1, 3'h1);
    flt(MODE_8, 32'h0, 32'haa, 32'h0, 32'h0, 1'b1, 3'h4);
    flt(MODE_8, 32'h0, 32'h0, 32'hff000000, 32'h0, 1'b1, 3'h3);
    flt(MODE_8, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0, 3'h0);
    flt(MODE_CLOSED, 32'h0, 32'h0, 32'hffffffff, 32'hffffffff, 1'b0, 3'h0);
    $display("test filter done");
  endtask : t_flt

  // priority selection, retry reselection, abort granted and refused
  task automatic t_tx;
    logic v;
    logic [1:0] s;
    logic [7:0] b;
    logic [31:0] q;
    u_eng.arbitrate(v, s);
    chk(v, 32'h0);
    wr(8'h80, 32'ha0);
    wr(8'h90, 32'ha1);
    wr(8'ha0, 32'hb7a2);
    wr(8'hac, 32'h5a);
    wr(OFS_LOCAL_PRIORITY_FIELD, 32'h00051020);
    wr(OFS_TX_FLAG, 32'h77);
    chk({intTx, txPending}, 32'h1);
    u_eng.arbitrate(v, s);
    chk({v, s}, 32'h6);
    u_eng.rd_byte(4'h0, b);
    chk(b, 32'ha2);
    u_eng.rd_byte(4'h1, b);
    chk(b, 32'hb7);
    u_eng.rd_byte(4'hc, b);
    chk(b, 32'h5a);
    u_eng.pulse(0);
    chk(ackSuppress, 32'h1);
    u_eng.pulse(1);
    rd(OFS_TX_FLAG, 32'h74);
    chk({intTx, ackSuppress}, 32'h2);
    u_eng.arbitrate(v, s);
    chk({v, s}, 32'h5);
    u_eng.pulse(0);
    u_eng.pulse(2);
    wr(OFS_LOCAL_PRIORITY_FIELD, 32'h00051001);
    u_eng.arbitrate(v, s);
    chk({v, s}, 32'h4);
    wr(OFS_TX_CTRL, 32'h2);
    bus(1'b0, OFS_TX_CTRL, 32'h0, q);
    chk(q & 32'h70, 32'h20);
    rd(OFS_TX_FLAG, 32'h76);
    u_eng.pulse(0);
    wr(OFS_TX_CTRL, 32'h1);
    rd(OFS_TX_FLAG, 32'h76);
    u_eng.pulse(1);
    rd(OFS_TX_FLAG, 32'h77);
    bus(1'b0, OFS_TX_CTRL, 32'h0, q);
    chk(q & 32'h70, 32'h20);
    chk(txPending, 32'h0);
    $display("test tx done");
  endtask : t_tx

  // reset in mid-run restores defaults; a masked receive raises no interrupt
  task automatic t_rerst;
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk(avs_waitrequest, 32'h1);
    rd(OFS_ACC_CTRL, 32'h0);
    rd(OFS_LOCAL_PRIORITY_FIELD, 32'h0);
    u_eng.send_frame(32'h0badcafe, 1'b0);
    rd(OFS_RX_FLAG, 32'h1);
    chk(intRx, 32'h0);
    wr(OFS_RX_FLAG, 32'h1);
    rd(OFS_RX_FLAG, 32'h0);
    $display("test reset again done");
  endtask : t_rerst

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // main sequence: reset for 20 cycles, then the tests in turn
  initial begin
    {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_rx;
    t_own;
    t_flt;
    t_tx;
    t_rerst;
    report_and_stop;
  end

  // watchdog at 20000 cycles, well beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 50);
    n_mismatch++;
    report_and_stop;
  end
endmodule : tb
